// File: inc/fcc_pkg.sv
// constants and carrier types of the flash card command controller
// assumes one 20 mhz clock, a card of up to sixteen chips on a 16-bit bus
//
// Notes on behaviour
// (RL1) FF/FFFF write returns chip to array read
// (RL2) 90/9090 then two reads give ids
// (RL3) erase is 20 then D0 same zone
// (RL4) one 128 KB zone per erase
// (RL5) B0 suspends erase, D0 resumes it
// (RL6) program is 40 then data word
// (RL7) 10 is alternate program setup code
// (RL8) 70 makes next read return status
// (RL9) single 50 write clears status
// (RL10) address latched on strobe or enable rise
// (RL11) program data latched on same rising edge
// (RL12) status bit 7 one means engine ready
// (RL13) suspended erase reports engine ready
// (RL14) status bit 6 shows erase suspended
// (RL15) status bit 5 shows erase failure
// (RL16) status bit 4 shows program failure
// (RL17) status bit 3 shows low program supply
// (RL18) upper status byte mirrors lower byte
// (RL19) odd chip upper byte, even chip lower
// (RL20) sixteen chips in eight 16-bit pairs
// (RL21) sixteen 64K blocks per chip
// (RL22) clear status before program or erase
// (RL23) reserved status bits read zero
// (RL24) read-level supply inhibits program, erase
package fcc_pkg;
    // ****************************************************************
    // command codes (one byte, doubled on a 16-bit bus)
    // ****************************************************************
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT = 8'h10;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    // ****************************************************************
    // status bit positions
    // ****************************************************************
    localparam int ST_ERASE_ERR = 5;
    localparam int ST_PROG_ERR = 4;
    localparam int ST_SUPPLY_LOW = 3;
    // ****************************************************************
    // identifier addresses
    // ****************************************************************
    localparam logic [23:0] ID_MAKER_ADDR = 24'h000000;
    localparam logic [23:0] ID_DEVICE_ADDR = 24'h000001;
    // ****************************************************************
    // bus cycle timing in 50 ns clocks
    // ****************************************************************
    localparam int CLK_NS = 50;
    localparam int STROBE_NS = 200;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_CYC = 1;
    // ****************************************************************
    // user-side operations and their carrier
    // ****************************************************************
    typedef enum logic [2:0] {
        OP_READ_ARRAY, OP_READ_ID, OP_ERASE, OP_SUSPEND,
        OP_RESUME, OP_PROGRAM, OP_READ_STATUS, OP_CLEAR_STATUS
    } fcc_op_type;
    typedef struct packed {
        fcc_op_type op;
        logic wide;        // 16-bit organisation
        logic alt_setup;   // program uses the alternate setup code
        logic [23:0] addr;
        logic [15:0] data;
    } fcc_req_type;
    typedef struct packed {
        logic [15:0] word0;   // status, array word or maker code
        logic [15:0] word1;   // device code
        logic supply_low;
        logic erase_err;
        logic prog_err;
    } fcc_rsp_type;
endpackage

// File: hw/fcc_strobe.sv
// one card bus cycle: address and enables, then write or output strobe
// assumes the caller holds cyc_start for one clock while idle
module fcc_strobe
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // cycle request
    input wire logic cyc_start,
    input wire logic cyc_write,
    input wire logic cyc_wide,
    input wire logic [23:0] cyc_addr,
    input wire logic [15:0] cyc_wdata,
    output logic cyc_done,
    output logic [15:0] cyc_rdata,
    // card pins
    input wire logic [15:0] card_d_in,
    output logic [15:0] card_d_out,
    output logic [15:0] card_d_oe_n,
    output logic [23:0] card_a,
    output logic low_byte_select_n,
    output logic high_byte_select_n,
    output logic card_we_n,
    output logic card_oe_n
);
    // ****************************************************************
    // sequencer
    // ****************************************************************
    typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD} fcc_ph_type;
    fcc_ph_type ph_r, ph_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic wr_r, wr_nxt;   // latched direction
    logic wd_r, wd_nxt;   // latched width
    logic [15:0] d2_r, d3_r, d1_r;  // data input synchroniser
    logic [15:0] rd_r, rd_nxt;
    logic done_r, done_nxt;
    logic [23:0] a_nxt;
    logic [15:0] wdat_nxt;

    // next phase; the strobe is raised before enables so the card
    // latches address and data on that rising edge (see RL10) (see RL11)
    always_comb
    begin
        ph_nxt = ph_r;
        cnt_nxt = cnt_r;
        wr_nxt = wr_r;
        wd_nxt = wd_r;
        rd_nxt = rd_r;
        done_nxt = 1'b0;
        a_nxt = card_a;
        wdat_nxt = card_d_out;
        case (ph_r)
            S_IDLE:
            begin
                if (cyc_start)
                begin
                    ph_nxt = S_SETUP;
                    wr_nxt = cyc_write;
                    wd_nxt = cyc_wide;
                    a_nxt = cyc_addr;
                    wdat_nxt = cyc_wdata;
                    cnt_nxt = 4'(fcc_pkg::SETTLE_CYC);
                end
            end
            S_SETUP:
            begin
                if (cnt_r <= 4'h1)
                begin
                    ph_nxt = S_STROBE;
                    cnt_nxt = 4'(fcc_pkg::STROBE_CYC + 2);
                end
                else
                    cnt_nxt = cnt_r - 4'h1;
            end
            S_STROBE:
            begin
                // extra two clocks let the synchroniser catch read data
                if (cnt_r <= 4'h1)
                begin
                    ph_nxt = S_HOLD;
                    rd_nxt = d3_r;
                end
                else
                    cnt_nxt = cnt_r - 4'h1;
            end
            S_HOLD:
            begin
                ph_nxt = S_IDLE;
                done_nxt = 1'b1;
            end
            default: ph_nxt = S_IDLE;
        endcase
    end

    // registers and pins
    always_ff @(posedge clk_sys)
    begin
        d1_r <= card_d_in;
        d2_r <= d1_r;
        d3_r <= d2_r;
        if (!rst_n)
        begin
            ph_r <= S_IDLE;
            cnt_r <= 4'h0;
            wr_r <= 1'b0;
            wd_r <= 1'b0;
            rd_r <= 16'h0000;
            done_r <= 1'b0;
            card_we_n <= 1'b1;
            card_oe_n <= 1'b1;
            low_byte_select_n <= 1'b1;
            high_byte_select_n <= 1'b1;
            card_d_oe_n <= 16'hffff;
            card_d_out <= 16'h0000;
            card_a <= 24'h000000;
        end
        else
        begin
            ph_r <= ph_nxt;
            cnt_r <= cnt_nxt;
            wr_r <= wr_nxt;
            wd_r <= wd_nxt;
            rd_r <= rd_nxt;
            done_r <= done_nxt;
            card_a <= a_nxt;
            card_d_out <= wdat_nxt;
            // odd byte on the upper lane, even on the lower (see RL19)
            low_byte_select_n <= !(ph_nxt != S_IDLE
                && (wd_nxt || !a_nxt[0]));
            high_byte_select_n <= !(ph_nxt != S_IDLE
                && (wd_nxt || a_nxt[0]));
            card_we_n <= !(ph_nxt == S_STROBE && wr_nxt);
            card_oe_n <= !(ph_nxt == S_STROBE && !wr_nxt);
            card_d_oe_n <= (ph_nxt != S_IDLE && wr_nxt) ? 16'h0000
                : 16'hffff;
        end
    end

    assign cyc_done = done_r;
    assign cyc_rdata = rd_r;
endmodule

// File: hw/fcc_host.sv
// host controller that drives a flash memory card through its pins
// assumes one 20 mhz clock; the user holds a request until req_ready
module fcc_host
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // user request
    input wire logic req_valid,
    input wire fcc_pkg::fcc_req_type req,
    output logic req_ready,
    // user answer
    output logic rsp_valid,
    output fcc_pkg::fcc_rsp_type rsp,
    // card pins
    input wire logic [15:0] card_d_in,
    output logic [15:0] card_d_out,
    output logic [15:0] card_d_oe_n,
    output logic [23:0] card_a,
    output logic low_byte_select_n,
    output logic high_byte_select_n,
    output logic card_we_n,
    output logic card_oe_n
);
    // ****************************************************************
    // command sequencer
    // ****************************************************************
    typedef enum logic [1:0] {H_IDLE, H_CYC, H_WAIT, H_ANS} fcc_hs_type;
    fcc_hs_type st_r, st_nxt;
    fcc_pkg::fcc_req_type cur_r, cur_nxt;
    logic [1:0] step_r, step_nxt;   // bus cycle index in the command
    logic [1:0] last_r, last_nxt;   // index of final cycle
    fcc_pkg::fcc_rsp_type rsp_r, rsp_nxt;
    logic rv_r, rv_nxt;
    logic rdy_r, rdy_nxt;
    logic cyc_start_r, cyc_start_nxt;
    logic cyc_done;
    logic [15:0] cyc_rdata;
    logic cyc_write;
    logic [23:0] cyc_addr;
    logic [15:0] cyc_wdata;

    // doubles a code on a wide bus, both chips of a pair see it
    function automatic logic [15:0] code(input logic [7:0] c,
                                          input logic wide);
        code = wide ? {c, c} : {8'h00, c};
    endfunction

    // ****************************************************************
    // choice of the bus cycle for each step
    // ****************************************************************
    always_comb
    begin
        cyc_write = 1'b1;
        cyc_addr = cur_r.addr;
        cyc_wdata = 16'h0000;
        case (cur_r.op)
            fcc_pkg::OP_READ_ARRAY:
            begin
                // back to array mode, then read the word (see RL1)
                cyc_write = (step_r == 2'd0);
                cyc_wdata = code(fcc_pkg::CMD_READ_ARRAY, cur_r.wide);
            end
            fcc_pkg::OP_READ_ID:
            begin
                // command, then maker and device code reads (see RL2)
                cyc_write = (step_r == 2'd0);
                cyc_wdata = code(fcc_pkg::CMD_READ_ID, cur_r.wide);
                cyc_addr = (step_r == 2'd2) ? fcc_pkg::ID_DEVICE_ADDR
                    : fcc_pkg::ID_MAKER_ADDR;
            end
            fcc_pkg::OP_ERASE:
                // same zone address on both cycles (see RL3) (see RL4)
                cyc_wdata = (step_r == 2'd0)
                    ? code(fcc_pkg::CMD_ERASE_SETUP, cur_r.wide)
                    : code(fcc_pkg::CMD_CONFIRM, cur_r.wide);
            fcc_pkg::OP_SUSPEND:
                cyc_wdata = code(fcc_pkg::CMD_SUSPEND, cur_r.wide); // see RL5
            fcc_pkg::OP_RESUME:
                cyc_wdata = code(fcc_pkg::CMD_CONFIRM, cur_r.wide); // see RL5
            fcc_pkg::OP_PROGRAM:
                // setup code then the word itself (see RL6) (see RL7)
                cyc_wdata = (step_r != 2'd0) ? cur_r.data
                    : code(cur_r.alt_setup ? fcc_pkg::CMD_PROG_ALT
                    : fcc_pkg::CMD_PROG_SETUP, cur_r.wide);
            fcc_pkg::OP_READ_STATUS:
            begin
                cyc_write = (step_r == 2'd0);  // see RL8
                cyc_wdata = code(fcc_pkg::CMD_READ_STATUS, cur_r.wide);
            end
            fcc_pkg::OP_CLEAR_STATUS: // see RL9, RL22
                cyc_wdata = code(fcc_pkg::CMD_CLEAR_STATUS, cur_r.wide);
            default: cyc_write = 1'b1;
        endcase
    end

    // ****************************************************************
    // sequencer next state
    // ****************************************************************
    always_comb
    begin
        st_nxt = st_r;
        cur_nxt = cur_r;
        step_nxt = step_r;
        last_nxt = last_r;
        rsp_nxt = rsp_r;
        rv_nxt = 1'b0;
        rdy_nxt = 1'b0;
        cyc_start_nxt = 1'b0;
        case (st_r)
            H_IDLE:
            begin
                if (req_valid)
                begin
                    cur_nxt = req;
                    step_nxt = 2'd0;
                    rdy_nxt = 1'b1;
                    rsp_nxt = '0;
                    cyc_start_nxt = 1'b1;
                    st_nxt = H_WAIT;
                    case (req.op)
                        fcc_pkg::OP_READ_ID: last_nxt = 2'd2;
                        fcc_pkg::OP_READ_ARRAY,
                        fcc_pkg::OP_ERASE,
                        fcc_pkg::OP_PROGRAM,
                        fcc_pkg::OP_READ_STATUS: last_nxt = 2'd1;
                        default: last_nxt = 2'd0;
                    endcase
                end
            end
            H_CYC:
            begin
                cyc_start_nxt = 1'b1;
                st_nxt = H_WAIT;
            end
            H_WAIT:
            begin
                if (cyc_done)
                begin
                    // read data: status, array word, or maker then device code
                    if (!cyc_write && step_r != 2'd2)
                        rsp_nxt.word0 = cyc_rdata;
                    if (!cyc_write && step_r == 2'd2)
                        rsp_nxt.word1 = cyc_rdata;
                    if (step_r == last_r)
                        st_nxt = H_ANS;
                    else
                    begin
                        step_nxt = step_r + 2'd1;
                        st_nxt = H_CYC;
                    end
                end
            end
            H_ANS:
            begin
                // error summary of a status read; a wide bus ors both
                // chips' copies (see RL18), reserved bits ignored (see RL23)
                rsp_nxt.supply_low = rsp_r.word0[fcc_pkg::ST_SUPPLY_LOW]
                    | (cur_r.wide & rsp_r.word0[fcc_pkg::ST_SUPPLY_LOW+8]);
                rsp_nxt.erase_err = rsp_r.word0[fcc_pkg::ST_ERASE_ERR]
                    | (cur_r.wide & rsp_r.word0[fcc_pkg::ST_ERASE_ERR+8]);
                rsp_nxt.prog_err = rsp_r.word0[fcc_pkg::ST_PROG_ERR]
                    | (cur_r.wide & rsp_r.word0[fcc_pkg::ST_PROG_ERR+8]);
                if (cur_r.op != fcc_pkg::OP_READ_STATUS)
                begin
                    rsp_nxt.supply_low = 1'b0;
                    rsp_nxt.erase_err = 1'b0;
                    rsp_nxt.prog_err = 1'b0;
                end
                rv_nxt = 1'b1;
                st_nxt = H_IDLE;
            end
            default: st_nxt = H_IDLE;
        endcase
    end

    // registers
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st_r <= H_IDLE;
            cur_r <= '0;
            step_r <= 2'd0;
            last_r <= 2'd0;
            rsp_r <= '0;
            rv_r <= 1'b0;
            rdy_r <= 1'b0;
            cyc_start_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            cur_r <= cur_nxt;
            step_r <= step_nxt;
            last_r <= last_nxt;
            rsp_r <= rsp_nxt;
            rv_r <= rv_nxt;
            rdy_r <= rdy_nxt;
            cyc_start_r <= cyc_start_nxt;
        end
    end

    assign req_ready = rdy_r;
    assign rsp_valid = rv_r;
    assign rsp = rsp_r;

    // ****************************************************************
    // bus cycle engine
    // ****************************************************************
    fcc_strobe u_strobe
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .cyc_start(cyc_start_r),
        .cyc_write(cyc_write),
        .cyc_wide(cur_r.wide),
        .cyc_addr(cyc_addr),
        .cyc_wdata(cyc_wdata),
        .cyc_done(cyc_done),
        .cyc_rdata(cyc_rdata),
        .card_d_in(card_d_in),
        .card_d_out(card_d_out),
        .card_d_oe_n(card_d_oe_n),
        .card_a(card_a),
        .low_byte_select_n(low_byte_select_n),
        .high_byte_select_n(high_byte_select_n),
        .card_we_n(card_we_n),
        .card_oe_n(card_oe_n)
    );
endmodule

// File: tb/fcc_host_props.sv
// concurrent checks on the card pins and user handshake of fcc_host
// assumes it is bound into fcc_host and sees only that module's ports
module fcc_host_props
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // user side
    input wire logic req_ready,
    input wire logic rsp_valid,
    // card pins
    input wire logic [15:0] card_d_out,
    input wire logic [15:0] card_d_oe_n,
    input wire logic [23:0] card_a,
    input wire logic low_byte_select_n,
    input wire logic high_byte_select_n,
    input wire logic card_we_n,
    input wire logic card_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // ****************************************************************
    // strobe shapes
    // ****************************************************************
    // both strobes stay low six clocks, then end the cycle by rising
    sequence we_pulse_s;
        !card_we_n [*6] ##1 card_we_n;
    endsequence
    sequence oe_pulse_s;
        !card_oe_n [*6] ##1 card_oe_n;
    endsequence
    logic sel; // any byte lane enabled
    assign sel = !low_byte_select_n || !high_byte_select_n;
    chk_we_width: assert property (
        $fell(card_we_n) |-> we_pulse_s)
        else $error("write strobe width wrong");
    chk_oe_width: assert property (
        $fell(card_oe_n) |-> oe_pulse_s)
        else $error("output strobe width wrong");
    chk_strobe_excl: assert property (
        !(!card_we_n && !card_oe_n))
        else $error("both strobes low");
    chk_sel_write: assert property (
        !card_we_n |-> sel && $stable(card_a) && $stable(card_d_out))
        else $error("address or data moved in write strobe");
    // the latching edge must still see an enabled card and driven data
    chk_sel_rise: assert property (
        $rose(card_we_n) |-> sel && card_d_oe_n == 16'h0000)
        else $error("card released before strobe rise");
    chk_read_release: assert property (
        !card_oe_n |-> card_d_oe_n == 16'hffff && sel)
        else $error("host drives data during a read");
    chk_narrow_lane: assert property (
        !card_we_n && (low_byte_select_n != high_byte_select_n)
        |-> card_d_out[15:8] == 8'h00)
        else $error("narrow write uses upper byte");
    chk_ready_pulse: assert property (
        req_ready |=> !req_ready)
        else $error("ready longer than one clock");
    chk_rsp_pulse: assert property (
        rsp_valid |-> card_we_n && card_oe_n ##1 !rsp_valid)
        else $error("answer pulse wrong");
endmodule
bind fcc_host fcc_host_props fcc_host_props_i (.*);

// File: tb/fcc_card_model.sv
// behavioural flash card as seen from its pins, no clock of its own
// assumes the host strobes with a byte select low; erase ends after
// two status reads so that busy and suspend can be seen
module fcc_card_model
#(
    parameter logic [7:0] MAKER = 8'h3c, // arbitrary value
    parameter logic [7:0] DEVICE = 8'h5e // arbitrary value
)
(
    // card pins
    output logic [15:0] card_d_in,
    input wire logic [15:0] card_d_out,
    input wire logic [23:0] card_a,
    input wire logic low_byte_select_n,
    input wire logic high_byte_select_n,
    input wire logic card_we_n,
    input wire logic card_oe_n,
    // test controls
    input wire logic vpp_low,
    input wire logic fault,
    output logic [15:0] last_w
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [int]; // unwritten words read erased
    logic [1:0] mode = 2'd0; // 0 array, 1 id, 2 status
    logic [1:0] pend = 2'd0; // 1 program, 2 erase awaiting next write
    logic [7:0] st = 8'h80; // reserved bits never set
    logic [1:0] busy = 2'd0; // status reads left before erase ends
    logic [23:0] zone = 24'h0;
    logic [15:0] rd_v = 16'h0;
    logic [15:0] last_rd = 16'h0;
    logic sel;
    assign sel = !low_byte_select_n || !high_byte_select_n;
    // released bus shows the inverse of the last value, never a hold
    assign card_d_in = (!card_oe_n && sel) ? rd_v : ~last_rd;
    // ****************************************************************
    // write cycles, latched at the strobe's rising edge
    // ****************************************************************
    always @(posedge card_we_n)
        if (sel)
        begin
            last_w = card_d_out;
            if (pend == 2'd1)
            begin
                pend = 2'd0;
                if (vpp_low)
                    st[3] = 1'b1;
                else if (fault)
                    st[4] = 1'b1;
                else
                    mem[card_a] = card_d_out;
            end
            else if (pend == 2'd2)
            begin
                pend = 2'd0;
                if (card_d_out[7:0] == 8'hd0 && card_a == zone)
                    if (vpp_low)
                        st[3] = 1'b1;
                    else
                        busy = 2'd2;
                st[7] = (busy == 2'd0);
            end
            else
                case (card_d_out[7:0])
                    8'hff: mode = 2'd0;
                    8'h90: mode = 2'd1;
                    8'h70: mode = 2'd2;
                    8'h50: st[5:3] = 3'b000;
                    8'h40, 8'h10: pend = 2'd1;
                    8'h20:
                    begin
                        pend = 2'd2;
                        zone = card_a;
                    end
                    8'hb0: if (busy) st[7:6] = 2'b11;
                    8'hd0: if (st[6]) st[7:6] = 2'b00;
                    default: ;
                endcase
        end
    // ****************************************************************
    // read cycles
    // ****************************************************************
    always @(negedge card_oe_n)
        case (mode)
            2'd1: rd_v = {2{card_a[0] ? DEVICE : MAKER}};
            2'd2: rd_v = {2{st}};
            default: rd_v = mem.exists(card_a) ? mem[card_a] : 16'hffff;
        endcase
    // a status read while erasing moves the erase on unless suspended
    always @(posedge card_oe_n)
        if (sel)
        begin
            last_rd = rd_v;
            if (mode == 2'd2 && busy != 2'd0 && !st[6])
            begin
                busy = busy - 2'd1;
                st[7] = (busy == 2'd0);
                if (busy == 2'd0 && fault)
                    st[5] = 1'b1;
                else if (busy == 2'd0)
                    foreach (mem[k])
                        if (k[23:17] == zone[23:17])
                            mem[k] = 16'hffff;
            end
        end
endmodule

// File: tb/flash_card_command_status_tb.sv
// self-checking bench of fcc_host against a behavioural card
// assumes fcc_pkg, fcc_host and the card model are compiled first
module flash_card_command_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
    localparam logic [7:0] DEVICE = 8'h5e; // arbitrary value
    localparam logic [23:0] A1 = 24'h020010; // zone 1
    localparam logic [23:0] A2 = 24'h040020; // zone 2
    logic clk_sys = 1'b0;
    logic rst_n, req_valid, req_ready, rsp_valid, vpp_low, fault;
    fcc_pkg::fcc_req_type req;
    fcc_pkg::fcc_rsp_type rsp;
    logic [15:0] card_d_in, card_d_out, card_d_oe_n, last_w;
    logic [23:0] card_a;
    logic low_byte_select_n, high_byte_select_n, card_we_n, card_oe_n;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    always #25 clk_sys = ~clk_sys;
    fcc_host fcc_host_i (.*);
    fcc_card_model #(.MAKER(MAKER), .DEVICE(DEVICE)) fcc_card_model_i (.*);
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic test_done();
        if (num_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // request held until ready is seen, answer read where it settled
    task automatic do_op(input fcc_pkg::fcc_op_type o, input logic w = 1'b1,
        input logic alt = 1'b0, input logic [23:0] ad = A1,
        input logic [15:0] d = 16'h0);
        int n;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= '{o, w, alt, ad, d};
        n = 0;
        do
            @(negedge clk_sys);
        while (req_ready !== 1'b1 && ++n < 400);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        do
            @(negedge clk_sys);
        while (rsp_valid !== 1'b1 && ++n < 800);
        if (n >= 800)
            num_errors++;
    endtask
    task automatic st_is(input logic [15:0] e);
        do_op(fcc_pkg::OP_READ_STATUS);
        check(rsp.word0, e);
    endtask
    task automatic rd_is(input logic [23:0] ad, input logic [15:0] e);
        do_op(fcc_pkg::OP_READ_ARRAY, , , ad);
        check(rsp.word0, e);
    endtask
    // a hang counts as a mismatch and closes the run
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            test_done();
        end
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        vpp_low = 1'b0;
        fault = 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        check({card_we_n, card_oe_n, low_byte_select_n}, 16'h0007);
        check(card_d_oe_n, 16'hffff);
        do_op(fcc_pkg::OP_CLEAR_STATUS);
        check(last_w, 16'h5050);
        st_is(16'h8080);
        check(last_w, 16'h7070);
        do_op(fcc_pkg::OP_READ_STATUS, 1'b0);
        check({8'h00, rsp.word0[7:0]}, 16'h0080);
        do_op(fcc_pkg::OP_READ_ID);
        check(rsp.word0, {2{MAKER}});
        check(rsp.word1, {2{DEVICE}});
        do_op(fcc_pkg::OP_READ_ID, 1'b0);
        check({rsp.word0[7:0], rsp.word1[7:0]}, {MAKER, DEVICE});
        // both program setups, then array read back
        do_op(fcc_pkg::OP_PROGRAM, 1'b1, 1'b0, A1, 16'h1234);
        check(last_w, 16'h1234);
        do_op(fcc_pkg::OP_PROGRAM, 1'b1, 1'b1, A2, 16'h5a3c);
        rd_is(A1, 16'h1234);
        check(last_w, 16'hffff);
        rd_is(A2, 16'h5a3c);
        // erase with a suspend in the middle
        do_op(fcc_pkg::OP_ERASE);
        check(last_w, 16'hd0d0);
        st_is(16'h0000);
        do_op(fcc_pkg::OP_SUSPEND);
        check(last_w, 16'hb0b0);
        st_is(16'hc0c0);
        do_op(fcc_pkg::OP_RESUME);
        check(last_w, 16'hd0d0);
        st_is(16'h0000);
        st_is(16'h8080);
        rd_is(A1, 16'hffff);
        rd_is(A2, 16'h5a3c);
        // low program supply aborts and is flagged
        @(posedge clk_sys);
        vpp_low <= 1'b1;
        do_op(fcc_pkg::OP_PROGRAM, 1'b1, 1'b0, A1, 16'h0f0f);
        st_is(16'h8888);
        check({15'h0, rsp.supply_low}, 16'h0001);
        vpp_low <= 1'b0;
        rd_is(A1, 16'hffff);
        do_op(fcc_pkg::OP_CLEAR_STATUS);
        st_is(16'h8080);
        check({15'h0, rsp.supply_low}, 16'h0000);
        // failing program and erase
        @(posedge clk_sys);
        fault <= 1'b1;
        do_op(fcc_pkg::OP_PROGRAM, 1'b1, 1'b0, A1, 16'h0f0f);
        st_is(16'h9090);
        check({15'h0, rsp.prog_err}, 16'h0001);
        do_op(fcc_pkg::OP_CLEAR_STATUS);
        do_op(fcc_pkg::OP_ERASE, , , A2);
        repeat (2) st_is(16'h0000);
        st_is(16'ha0a0);
        check({15'h0, rsp.erase_err}, 16'h0001);
        fault <= 1'b0;
        test_done();
    end
endmodule
